// file: rtl/arc_pkg.sv
package arc_pkg;
   // clock and time base
   localparam int CLK_HZ          = 20_000_000;
   localparam int MS_PER_S        = 1000;
   localparam int TCR_CELLS_PER_S = 10;
   localparam int MS_CYCLES       = CLK_HZ / MS_PER_S;
   localparam int TCR_CYCLES      = CLK_HZ / TCR_CELLS_PER_S;
   localparam int RATE_W          = 24;
   localparam int ACC_W           = 26;
   // register byte offsets
   localparam logic [7:0] ADR_CTRL   = 8'h00;
   localparam logic [7:0] ADR_PEAK   = 8'h04;
   localparam logic [7:0] ADR_MIN    = 8'h08;
   localparam logic [7:0] ADR_INIT   = 8'h0c;
   localparam logic [7:0] ADR_COUNT  = 8'h10;
   localparam logic [7:0] ADR_CRM    = 8'h14;
   localparam logic [7:0] ADR_TIME   = 8'h18;
   localparam logic [7:0] ADR_FACT   = 8'h1c;
   localparam logic [7:0] ADR_STATUS = 8'h20;
   // field positions
   localparam int F_EN        = 0;
   localparam int F_NI        = 1;
   localparam int F_MRM_LSB   = 8;
   localparam int F_IDLE_DECREASE_TIME_LSB  = 16;
   localparam int F_RDF_LSB   = 8;
   localparam int F_RIF_LSB   = 16;
   localparam int F_FIRST     = 24;
   // reset values
   localparam logic [23:0] PEAK_RST = 24'h002710;
   localparam logic [23:0] MIN_RST  = 24'h000000;
   localparam logic [23:0] INIT_RST = 24'h002710;
   localparam logic [7:0]  NRM_RST  = 8'h20;
   localparam logic [7:0]  MRM_RST  = 8'h02;
   localparam logic [23:0] CRM_RST  = 24'h080000;
   localparam logic [15:0] TRM_RST  = 16'h0064;
   localparam logic [15:0] IDLE_DECREASE_TIME_RST = 16'h01f4;
   localparam logic [4:0]  CDF_RST  = 5'h04;
   localparam logic [4:0]  RDF_RST  = 5'h0f;
   localparam logic [4:0]  RIF_RST  = 5'h00;
   // control cell layout
   localparam logic [7:0]  RM_PID      = 8'h01;
   localparam logic        DIR_FWD     = 1'b0;
   localparam logic        BN_SRC      = 1'b0;
   localparam logic        CI_SRC      = 1'b0;
   localparam logic [3:0]  OCT7_LOW    = 4'h0;
   localparam logic [7:0]  RM_FILL     = 8'h6a;
   localparam int          FILL_OCTETS = 30;
   localparam logic [63:0] QL_SN       = 64'h0;
   localparam logic [5:0]  TAIL_ZERO   = 6'h00;
   localparam int          CRC_BITS    = 374;
   localparam logic [9:0]  CRC_POLY    = 10'h233;
   // rate word layout
   localparam int RATE_NZ  = 14;
   localparam int RATE_E   = 9;
   localparam int RATE_EMX = 23;
   localparam int MANT_W   = 9;

   typedef enum logic [1:0] {
      ARC_KIND_NONE = 2'b00,
      ARC_KIND_FWD  = 2'b01,
      ARC_KIND_BWD  = 2'b10,
      ARC_KIND_DATA = 2'b11
   } arc_kind_t;

   function automatic logic [15:0] rate_enc(input logic [23:0] r);
      logic [4:0]  e;
      logic [32:0] t;
      e = 5'h00;
      for (int i = 0; i < RATE_W; i++) begin
         if (r[i]) e = 5'(i);
      end
      t = {r, 9'h000} >> e;
      rate_enc = (r == 24'h0) ? 16'h0000 :
                 {1'b0, 1'b1, e, t[MANT_W-1:0]};
   endfunction : rate_enc

   function automatic logic [23:0] rate_dec(input logic [15:0] f);
      logic [4:0]  e;
      logic [41:0] v;
      e = f[RATE_E +: 5];
      v = {32'h0, 1'b1, f[MANT_W-1:0]} << e;
      if (!f[RATE_NZ]) rate_dec = 24'h000000;
      else if (int'(e) > RATE_EMX) rate_dec = 24'hffffff;
      else rate_dec = v[MANT_W +: RATE_W];
   endfunction : rate_dec

   function automatic logic [9:0] crc10(input logic [373:0] d);
      logic [9:0] c;
      logic       fb;
      c = 10'h000;
      for (int i = CRC_BITS - 1; i >= 0; i--) begin
         fb = c[9] ^ d[i];
         c  = {c[8:0], 1'b0} ^ (fb ? CRC_POLY : 10'h000);
      end
      crc10 = c;
   endfunction : crc10
endpackage : arc_pkg

// file: rtl/arc_source_ctrl.sv
`timescale 1ns/1ps
module arc_source_ctrl #(
   parameter int MS_CYC  = arc_pkg::MS_CYCLES,
   parameter int TCR_CYC = arc_pkg::TCR_CYCLES
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        data_waiting,
   input  wire logic        bwd_waiting,
   input  wire logic        oor_fwd_req,
   output logic             cell_valid,
   output arc_pkg::arc_kind_t cell_kind,
   output logic             cell_clp,
   input  wire logic        cell_ready,
   output logic             tx_clp,
   output logic             tx_forward_congestion_indication,
   output logic [7:0]       rm_id,
   output logic             rm_dir,
   output logic             rm_bn,
   output logic             rm_ci,
   output logic             rm_ni,
   output logic [15:0]      rm_er,
   output logic [15:0]      rm_ccr,
   output logic [15:0]      rm_mcr,
   output logic [9:0]       rm_crc,
   input  wire logic        fb_valid,
   input  wire logic        fb_dir,
   input  wire logic        fb_bn,
   input  wire logic        fb_ci,
   input  wire logic        fb_ni,
   input  wire logic [15:0] fb_er
);
   localparam int MS_W  = $clog2(MS_CYC);
   localparam int TCR_W = $clog2(TCR_CYC + 1);
   localparam int ACC_W = arc_pkg::ACC_W;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // configuration, static while a connection runs
   logic        ctrl_en;
   logic        ni_req;
   logic [23:0] peak;
   logic [23:0] min_r;
   logic [23:0] init_r;
   logic [7:0]  nrm;
   logic [7:0]  mrm;
   logic [23:0] missing_feedback_limit;
   logic [15:0] trm_ms;
   logic [15:0] idle_decrease_time_ms;
   logic [4:0]  cdf_sh;
   logic [4:0]  rdf_sh;
   logic [4:0]  rif_sh;
   // connection state
   logic              en_q;
   logic              first_done;
   logic [23:0]       allowed_rate;
   logic [7:0]        cells_since;
   logic [15:0]       ms_since;
   logic [23:0]       fwd_nofb;
   logic              bwd_since;
   logic [MS_W-1:0]   ms_div;
   logic [ACC_W-1:0]  acc;
   logic [TCR_W-1:0]  tcr_cnt;

   // bus decode
   wire        wr_acc = psel & penable & pwrite;
   wire        hit    = paddr == arc_pkg::ADR_CTRL  |
                        paddr == arc_pkg::ADR_PEAK  |
                        paddr == arc_pkg::ADR_MIN   |
                        paddr == arc_pkg::ADR_INIT  |
                        paddr == arc_pkg::ADR_COUNT |
                        paddr == arc_pkg::ADR_CRM   |
                        paddr == arc_pkg::ADR_TIME  |
                        paddr == arc_pkg::ADR_FACT  |
                        paddr == arc_pkg::ADR_STATUS;
   wire [31:0] rd_mux =
      (paddr == arc_pkg::ADR_CTRL)  ? {30'h0, ni_req, ctrl_en} :
      (paddr == arc_pkg::ADR_PEAK)  ? {8'h00, peak} :
      (paddr == arc_pkg::ADR_MIN)   ? {8'h00, min_r} :
      (paddr == arc_pkg::ADR_INIT)  ? {8'h00, init_r} :
      (paddr == arc_pkg::ADR_COUNT) ? {16'h0, mrm, nrm} :
      (paddr == arc_pkg::ADR_CRM)   ? {8'h00, missing_feedback_limit} :
      (paddr == arc_pkg::ADR_TIME)  ? {idle_decrease_time_ms, trm_ms} :
      (paddr == arc_pkg::ADR_FACT)  ?
         {11'h0, rif_sh, 3'h0, rdf_sh, 3'h0, cdf_sh} :
      (paddr == arc_pkg::ADR_STATUS) ? {7'h0, first_done, allowed_rate} :
      32'h0;
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~hit;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
      end else if (psel & ~penable) begin
         prdata <= rd_mux;
      end
   end

   // parameters loaded before the connection is enabled
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_en <= 1'b0;
         ni_req  <= 1'b0;
         peak    <= arc_pkg::PEAK_RST;
         min_r   <= arc_pkg::MIN_RST;
         init_r  <= arc_pkg::INIT_RST;
         nrm     <= arc_pkg::NRM_RST;
         mrm     <= arc_pkg::MRM_RST;
         missing_feedback_limit     <= arc_pkg::CRM_RST;
         trm_ms  <= arc_pkg::TRM_RST;
         idle_decrease_time_ms <= arc_pkg::IDLE_DECREASE_TIME_RST;
         cdf_sh  <= arc_pkg::CDF_RST;
         rdf_sh  <= arc_pkg::RDF_RST;
         rif_sh  <= arc_pkg::RIF_RST;
      end else if (wr_acc) begin
         case (paddr)
            arc_pkg::ADR_CTRL: begin
               ctrl_en <= pwdata[arc_pkg::F_EN];
               ni_req  <= pwdata[arc_pkg::F_NI];
            end
            arc_pkg::ADR_PEAK: peak   <= pwdata[23:0];
            arc_pkg::ADR_MIN:  min_r  <= pwdata[23:0];
            arc_pkg::ADR_INIT: init_r <= pwdata[23:0];
            arc_pkg::ADR_COUNT: begin
               nrm <= pwdata[7:0];
               mrm <= pwdata[arc_pkg::F_MRM_LSB +: 8];
            end
            arc_pkg::ADR_CRM: missing_feedback_limit <= pwdata[23:0];
            arc_pkg::ADR_TIME: begin
               trm_ms  <= pwdata[15:0];
               idle_decrease_time_ms <= pwdata[arc_pkg::F_IDLE_DECREASE_TIME_LSB +: 16];
            end
            arc_pkg::ADR_FACT: begin
               cdf_sh <= pwdata[4:0];
               rdf_sh <= pwdata[arc_pkg::F_RDF_LSB +: 5];
               rif_sh <= pwdata[arc_pkg::F_RIF_LSB +: 5];
            end
            default: ;
         endcase
      end
   end

   // scheduling of the next cell
   wire start   = ctrl_en & ~en_q;
   wire running = ctrl_en & en_q;
   wire credit  = acc >= ACC_W'(arc_pkg::CLK_HZ);
   wire ms_tick = ms_div == MS_W'(MS_CYC - 1);
   wire inrate_ok = running & credit;
   wire fwd_cond  = ~first_done | (cells_since >= nrm - 8'h01)
                  | (cells_since >= mrm & ms_since >= trm_ms);
   wire bwd_cond  = bwd_waiting & (~bwd_since | ~data_waiting);
   wire oor_ok    = running & oor_fwd_req & tcr_cnt == '0;
   wire in_fwd    = inrate_ok & fwd_cond;
   wire in_bwd    = inrate_ok & ~fwd_cond & bwd_cond;
   wire in_data   = inrate_ok & ~fwd_cond & ~bwd_cond & data_waiting;
   wire oor_fwd   = ~(in_fwd | in_bwd | in_data) & oor_ok;

   assign cell_valid = in_fwd | in_bwd | in_data | oor_fwd;
   assign cell_kind  = (in_fwd | oor_fwd) ? arc_pkg::ARC_KIND_FWD :
                       in_bwd  ? arc_pkg::ARC_KIND_BWD :
                       in_data ? arc_pkg::ARC_KIND_DATA :
                       arc_pkg::ARC_KIND_NONE;
   assign cell_clp   = oor_fwd;

   wire sent      = cell_valid & cell_ready;
   wire in_sent   = sent & ~oor_fwd;
   wire fwd_in    = sent & in_fwd;
   wire oor_sent  = sent & oor_fwd;
   wire fb_bwd    = fb_valid & fb_dir;

   // adjustments before an in-rate forward cell
   wire [23:0] r_idle_decrease_time = (allowed_rate > init_r & ms_since > idle_decrease_time_ms) ?
                        init_r : allowed_rate;
   wire [23:0] cdf_dec = (r_idle_decrease_time >> cdf_sh) + 24'h000001;
   wire [23:0] r_crm   = (fwd_nofb < missing_feedback_limit) ? r_idle_decrease_time :
                         (r_idle_decrease_time - min_r > cdf_dec) ? r_idle_decrease_time - cdf_dec :
                         min_r;
   wire [23:0] fwd_rate = fwd_in ? r_crm : allowed_rate;

   // adjustments on returned feedback
   wire [23:0] rdf_dec = (fwd_rate >> rdf_sh) + 24'h000001;
   wire [23:0] rif_inc = peak >> rif_sh;
   wire [23:0] r_cut   = (fwd_rate - min_r > rdf_dec) ?
                         fwd_rate - rdf_dec : min_r;
   wire [24:0] r_sum   = {1'b0, fwd_rate} + {1'b0, rif_inc};
   wire [23:0] r_up    = (r_sum > {1'b0, peak}) ? peak : r_sum[23:0];
   wire [23:0] r_fb    = fb_ci ? r_cut :
                         fb_ni ? fwd_rate : r_up;
   wire [23:0] er_rate = arc_pkg::rate_dec(fb_er);
   wire [23:0] r_er    = (r_fb < er_rate) ? r_fb : er_rate;
   wire [23:0] r_lim   = (r_er < min_r) ? min_r : r_er;
   wire [23:0] next_acr = fb_bwd ? r_lim : fwd_rate;
   wire [23:0] init_lim = (init_r > peak) ? peak :
                          (init_r < min_r) ? min_r : init_r;

   // source-generated forward cell payload
   wire [15:0]  er_f  = arc_pkg::rate_enc(peak);
   wire [15:0]  ccr_f = arc_pkg::rate_enc(fwd_rate);
   wire [15:0]  mcr_f = arc_pkg::rate_enc(min_r);
   wire [373:0] payload = {arc_pkg::RM_PID,
      arc_pkg::DIR_FWD, arc_pkg::BN_SRC,
      arc_pkg::CI_SRC, ni_req, arc_pkg::OCT7_LOW,
      er_f[15:8], er_f[7:0], ccr_f[15:8], ccr_f[7:0],
      mcr_f[15:8], mcr_f[7:0], arc_pkg::QL_SN,
      {arc_pkg::FILL_OCTETS{arc_pkg::RM_FILL}}, arc_pkg::TAIL_ZERO};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_q       <= 1'b0;
         first_done <= 1'b0;
         allowed_rate        <= 24'h000000;
      end else begin
         en_q <= ctrl_en;
         if (start) begin
            first_done <= 1'b0;
            allowed_rate        <= init_lim;
         end else if (running) begin
            first_done <= first_done | fwd_in;
            allowed_rate        <= next_acr;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cells_since <= 8'h00;
         bwd_since   <= 1'b0;
      end else if (start | fwd_in) begin
         cells_since <= 8'h00;
         bwd_since   <= 1'b0;
      end else if (in_sent) begin
         cells_since <= cells_since + {7'h0, cells_since != 8'hff};
         bwd_since   <= bwd_since | in_bwd;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ms_div   <= '0;
         ms_since <= 16'h0000;
      end else begin
         ms_div <= ms_tick ? '0 : ms_div + MS_W'(1);
         if (start | fwd_in) ms_since <= 16'h0000;
         else if (ms_tick & ms_since != 16'hffff)
            ms_since <= ms_since + 16'h0001;
      end
   end

   // in-rate forward cells since the last source-originated feedback
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fwd_nofb <= 24'h000000;
      end else if (start) begin
         fwd_nofb <= 24'h000000;
      end else if (fb_bwd & ~fb_bn) begin
         fwd_nofb <= {23'h0, fwd_in};
      end else if (fwd_in & fwd_nofb != 24'hffffff) begin
         fwd_nofb <= fwd_nofb + 24'h000001;
      end
   end

   // rate pacing credit and tagged-limit spacing
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc     <= '0;
         tcr_cnt <= '0;
      end else begin
         if (start) acc <= ACC_W'(arc_pkg::CLK_HZ);
         else if (in_sent) acc <= acc - ACC_W'(arc_pkg::CLK_HZ);
         else if (~credit) acc <= acc + {2'b00, allowed_rate};
         if (oor_sent) tcr_cnt <= TCR_W'(TCR_CYC - 1);
         else if (tcr_cnt != '0) tcr_cnt <= tcr_cnt - TCR_W'(1);
      end
   end

   // fields of the cell just accepted
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_clp  <= 1'b0;
         tx_forward_congestion_indication <= 1'b0;
         rm_ni   <= 1'b0;
         rm_er   <= 16'h0000;
         rm_ccr  <= 16'h0000;
         rm_mcr  <= 16'h0000;
         rm_crc  <= 10'h000;
      end else if (sent) begin
         tx_clp  <= cell_clp;
         tx_forward_congestion_indication <= 1'b0;
         if (in_fwd | oor_fwd) begin
            rm_ni  <= ni_req;
            rm_er  <= er_f;
            rm_ccr <= ccr_f;
            rm_mcr <= mcr_f;
            rm_crc <= arc_pkg::crc10(payload);
         end
      end
   end
   assign rm_id  = arc_pkg::RM_PID;
   assign rm_dir = arc_pkg::DIR_FWD;
   assign rm_bn  = arc_pkg::BN_SRC;
   assign rm_ci  = arc_pkg::CI_SRC;

   sequence s_oor_sent;
      oor_sent;
   endsequence
   sequence s_fwd_in;
      fwd_in;
   endsequence

   a_rate_bounds: assert property (running & ~start & min_r <= peak
      |=> allowed_rate <= peak && allowed_rate >= min_r)
      else $error("allowed rate outside minimum and peak");
   a_first_fwd: assert property (cell_valid & ~first_done & ~cell_clp
      |-> cell_kind == arc_pkg::ARC_KIND_FWD)
      else $error("first in-rate cell not forward");
   a_nrm_fwd: assert property (cell_valid & ~cell_clp & nrm != 8'h00 &
      cells_since >= nrm - 8'h01 |-> cell_kind == arc_pkg::ARC_KIND_FWD)
      else $error("forward cell not forced after count");
   a_data_forward_congestion_indication: assert property (sent & in_data
      |=> ~tx_forward_congestion_indication & ~tx_clp)
      else $error("data cell with indication or priority set");
   a_fwd_ccr: assert property (s_fwd_in
      |=> rm_ccr == arc_pkg::rate_enc($past(fwd_rate)) && ~tx_clp)
      else $error("current rate field not adjusted rate");
   a_idle_drop: assert property (s_fwd_in ##0 (allowed_rate > init_r &
      ms_since > idle_decrease_time_ms & ~fb_bwd) |=> allowed_rate <= init_r)
      else $error("idle decrease not applied");
   a_ci_cut: assert property (fb_bwd & fb_ci & ~fwd_in & running
      & ~start & allowed_rate > min_r |=> allowed_rate < $past(allowed_rate))
      else $error("congestion feedback did not cut rate");
   a_ni_hold: assert property (fb_bwd & fb_ni & ~fwd_in & running
      & ~start |=> allowed_rate <= $past(allowed_rate))
      else $error("rate raised under no-increase");
   a_er_limit: assert property (fb_bwd & running & ~start
      & er_rate >= min_r |=> allowed_rate <= $past(er_rate))
      else $error("rate above returned explicit rate");
   a_tcr_pace: assert property (s_oor_sent |=> ~oor_sent [*8])
      else $error("out-of-rate forward cells too close");
   a_oor_clp: assert property (s_oor_sent |=> tx_clp)
      else $error("out-of-rate forward cell without priority one");
endmodule : arc_source_ctrl

// file: tb/arc_net_model.sv
`timescale 1ns/1ps
module arc_net_model (
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic               cell_valid,
   input  wire arc_pkg::arc_kind_t cell_kind,
   input  wire logic               cell_clp,
   input  wire logic               cell_ready,
   output logic                    bwd_waiting,
   output logic                    fb_valid,
   output logic                    fb_dir,
   output logic                    fb_bn,
   output logic                    fb_ci,
   output logic                    fb_ni,
   output logic [15:0]             fb_er
);
   logic take;
   assign take = cell_valid && cell_ready && !cell_clp;
   // reverse-flow peer flags one turned-around cell pending after each in-rate forward cell
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) bwd_waiting <= 1'b0;
      else if (take && cell_kind == arc_pkg::ARC_KIND_FWD) bwd_waiting <= 1'b1;
      else if (take && cell_kind == arc_pkg::ARC_KIND_BWD) bwd_waiting <= 1'b0;
   end
   initial begin
      fb_valid = 1'b0;
      fb_dir = 1'b1;
      fb_bn = 1'b1;
      fb_ci = 1'b1;
      fb_ni = 1'b1;
      fb_er = 16'hffff;
   end
   // one returned cell; qualifiers scramble once the pulse is over
   task reply(input logic d, input logic c, input logic n,
              input logic [15:0] e);
      fb_valid <= 1'b1;
      fb_dir <= d;
      fb_bn <= 1'b0;
      fb_ci <= c;
      fb_ni <= n;
      fb_er <= e;
      @(posedge pclk);
      fb_valid <= 1'b0;
      fb_dir <= ~d;
      fb_bn <= 1'b1;
      fb_ci <= ~c;
      fb_ni <= ~n;
      fb_er <= ~e;
      @(posedge pclk);
   endtask : reply
endmodule : arc_net_model

// file: tb/abr_source_rate_control_test.sv
`timescale 1ns/1ps
module abr_source_rate_control_test;
   logic               pclk, presetn, psel, penable, pwrite, pready;
   logic               pslverr, err, data_waiting, bwd_waiting;
   logic               oor_fwd_req, cell_valid, cell_clp, cell_ready;
   logic               tx_clp, tx_forward_congestion_indication, rm_dir, rm_bn, rm_ci, rm_ni;
   logic               fb_valid, fb_dir, fb_bn, fb_ci, fb_ni;
   logic               fwd_d, acc_d, clp_d;
   logic [7:0]         paddr, rm_id;
   logic [31:0]        pwdata, prdata, rd;
   logic [15:0]        rm_er, rm_ccr, rm_mcr, fb_er;
   logic [9:0]         rm_crc;
   arc_pkg::arc_kind_t cell_kind;
   arc_pkg::arc_kind_t kq[$];
   logic [15:0]        cq[$];
   int                 mismatches, checked, cyc, oor_t;
   arc_pkg::arc_kind_t pat[4] = '{arc_pkg::ARC_KIND_FWD,
      arc_pkg::ARC_KIND_BWD, arc_pkg::ARC_KIND_DATA, arc_pkg::ARC_KIND_DATA};
   logic [18:0]        fbt[4] = '{19'h56400, 19'h67fff, 19'h07fff, 19'h47fff};
   logic [31:0]        fba[4] = '{32'h40000, 32'h3fffc, 32'h3fffc, 32'hf4240};

   arc_source_ctrl #(.MS_CYC(20), .TCR_CYC(50)) dut (.pclk, .presetn,
      .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .data_waiting, .bwd_waiting, .oor_fwd_req, .cell_valid, .cell_kind,
      .cell_clp, .cell_ready, .tx_clp, .tx_forward_congestion_indication, .rm_id, .rm_dir, .rm_bn,
      .rm_ci, .rm_ni, .rm_er, .rm_ccr, .rm_mcr, .rm_crc, .fb_valid, .fb_dir,
      .fb_bn, .fb_ci, .fb_ni, .fb_er);
   arc_net_model net (.pclk, .presetn, .cell_valid, .cell_kind, .cell_clp,
      .cell_ready, .bwd_waiting, .fb_valid, .fb_dir, .fb_bn, .fb_ci,
      .fb_ni, .fb_er);

   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         mismatches++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task rdc(input string n, input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(n, e, rd);
   endtask : rdc

   task acr_is(input logic [31:0] e);
      apb(1'b0, arc_pkg::ADR_STATUS, 32'h0);
      chk("acr", e, {8'h00, rd[23:0]});
   endtask : acr_is

   task restart(input logic [31:0] c, input logic [31:0] i,
                input logic [31:0] ctl);
      wr(arc_pkg::ADR_CTRL, 32'h0);
      wr(arc_pkg::ADR_COUNT, c);
      wr(arc_pkg::ADR_INIT, i);
      kq.delete();
      cq.delete();
      wr(arc_pkg::ADR_CTRL, ctl);
   endtask : restart

   task await(input int n);
      int t;
      t = 0;
      while (cq.size() < n && t < 20000) begin
         @(posedge pclk);
         t++;
      end
      chk("fwd_cells", 32'(n), 32'(cq.size() >= n ? n : cq.size()));
   endtask : await

   function automatic logic [9:0] crc_of(input logic [373:0] d);
      logic [9:0] c;
      logic       f;
      c = 10'h000;
      for (int i = 373; i >= 0; i--) begin
         f = c[9] ^ d[i];
         c = {c[8:0], 1'b0} ^ (f ? 10'h233 : 10'h000);
      end
      return c;
   endfunction : crc_of

   task complete_run;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : complete_run

   // cell monitor: in-rate order, forward current rate, header bits, pacing
   always @(posedge pclk) begin
      if (acc_d) begin
         chk("tx_forward_congestion_indication", 32'h0, 32'(tx_forward_congestion_indication));
         chk("tx_clp", 32'(clp_d), 32'(tx_clp));
      end
      if (fwd_d) cq.push_back(rm_ccr);
      acc_d = cell_valid === 1'b1 && cell_ready === 1'b1;
      clp_d = cell_clp;
      fwd_d = acc_d && cell_kind === arc_pkg::ARC_KIND_FWD && !cell_clp;
      if (acc_d && !cell_clp) kq.push_back(cell_kind);
      if (acc_d && cell_clp) begin
         chk("oor_kind", 32'(pat[0]), 32'(cell_kind));
         chk("oor_gap", 32'h1, 32'(cyc - oor_t >= 50));
         oor_t = cyc;
      end
      cyc++;
   end

   initial begin
      repeat (90000) @(posedge pclk);
      mismatches++;
      $display("Error watchdog expected done seen timeout");
      complete_run();
   end

   initial begin
      {presetn, psel, penable, pwrite, data_waiting, oor_fwd_req} = 6'h00;
      {fwd_d, acc_d, clp_d} = 3'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      cell_ready = 1'b1;
      mismatches = 0;
      checked = 0;
      cyc = 0;
      oor_t = -1000;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rdc("peak", arc_pkg::ADR_PEAK, 32'h00002710);
      rdc("count", arc_pkg::ADR_COUNT, 32'h00000220);
      rdc("time", arc_pkg::ADR_TIME, 32'h01f40064);
      rdc("fact", arc_pkg::ADR_FACT, 32'h00000f04);
      apb(1'b0, 8'h24, 32'h0);
      chk("slverr", 32'h1, 32'(err));
      chk("unmapped", 32'h0, rd);
      $display("test registers done");
      wr(arc_pkg::ADR_CTRL, 32'h1);
      await(1);
      chk("first", 32'(pat[0]), 32'(kq[0]));
      chk("id", 32'h1, 32'(rm_id));
      chk("flags", 32'h0,
          32'({rm_dir, rm_bn, rm_ci, rm_ni}));
      chk("er", 32'h5a71, 32'(rm_er));
      chk("ccr", 32'h5a71, 32'(rm_ccr));
      chk("mcr", 32'h0, 32'(rm_mcr));
      chk("crc", 32'(crc_of({16'h0100, 48'h5a715a710000, 64'h0,
         {30{8'h6a}}, 6'h00})), 32'(rm_crc));
      acr_is(32'h2710);
      $display("test first cell done");
      wr(arc_pkg::ADR_PEAK, 32'h000f4240);
      restart(32'h0000ff04, 32'h000f4240, 32'h3);
      data_waiting <= 1'b1;
      oor_fwd_req <= 1'b1;
      await(3);
      for (int i = 0; i < 9; i++) begin
         chk("order", 32'(pat[i%4]), 32'(kq[i]));
      end
      chk("ni", 32'h1, 32'(rm_ni));
      data_waiting <= 1'b0;
      oor_fwd_req <= 1'b0;
      $display("test order done");
      wr(arc_pkg::ADR_MIN, 32'h0003fffc);
      wr(arc_pkg::ADR_TIME, 32'h0002ffff);
      restart(32'h0000ff03, 32'h00080000, 32'h1);
      await(1);
      acr_is(32'h80000);
      for (int i = 0; i < 4; i++) begin
         net.reply(fbt[i][18], fbt[i][17], fbt[i][16], fbt[i][15:0]);
         acr_is(fba[i]);
      end
      $display("test feedback done");
      data_waiting <= 1'b1;
      await(2);
      chk("idle_ccr", 32'h6600, 32'(cq[1]));
      chk("bwd_next", 32'(pat[1]), 32'(kq[1]));
      chk("data_next", 32'(pat[2]), 32'(kq[2]));
      data_waiting <= 1'b0;
      $display("test idle drop done");
      wr(arc_pkg::ADR_MIN, 32'h0);
      wr(arc_pkg::ADR_CRM, 32'h2);
      restart(32'h0000ff01, 32'h000186a0, 32'h1);
      await(3);
      chk("ccr0", 32'h610d, 32'(cq[0]));
      chk("ccr1", 32'h610d, 32'(cq[1]));
      chk("ccr2", 32'h60dc, 32'(cq[2]));
      $display("test missing feedback done");
      complete_run();
   end
endmodule : abr_source_rate_control_test
